//--- rtl/du_dual.sv
// Purpose: Two independent serial channels behind a Wishbone slave
// Assumes: 16x oversampling from a divisor of CLK_I
// Notes:   FIFOs are always on; 1.5 stop bits are sent as 2
// Behaviour
// - Terminal-ready control bit set drives terminal-ready pin low, cleared high.
// - Terminal-ready pin is high after reset and when its bit is zero.
// - Request-to-send control bit set drives its pin low, cleared drives high.
// - Request-to-send pin is forced high at reset until software changes it.
// - Ring-indicator pin going high raises a modem status interrupt condition.
// - Clear-to-send pin state is readable in modem status bit 4.
// - Modem lines never gate transmit or receive operation.
// - Low carrier-detect pin means a carrier is present.
// - Serial output is high in reset, idle and when not sending.
// - Loop-back disables external serial pins and feeds transmitter into receiver.
// - Only the selected channel accepts configuration and data accesses.
// - Transmitter frames each character with start and stop bits.
// - Parity bit is attached when enabled and checked by the receiver.
// - Each channel has separate 16-byte transmit and receive FIFOs.
// - Four selectable receive fill thresholds each raise a receive interrupt.
// - Interrupt pin drives only with control bit 3 set, else floats.
// - Data and interrupt-enable registers are reachable only while divisor access bit is zero.
`timescale 1ns/10ps

module du_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             clear_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } du_fifo_type;
    du_fifo_type s_reg, s_next;
    logic push, pop;

    assign in_ready_o  = s_reg.cnt != (AW+1)'(DEPTH);
    assign out_valid_o = s_reg.cnt != '0;
    assign out_data_o  = s_reg.mem[s_reg.rp];
    assign count_o     = s_reg.cnt;

    always_comb begin
        s_next = s_reg;
        push   = in_valid_i & in_ready_o;
        pop    = out_ready_i & out_valid_o;
        if (push) begin
            s_next.mem[s_reg.wp] = in_data_i;
            s_next.wp = AW'(s_reg.wp + 1'b1);
        end
        if (pop) begin
            s_next.rp = AW'(s_reg.rp + 1'b1);
        end
        s_next.cnt = (AW+1)'(s_reg.cnt + push - pop);
        if (rst_i | clear_i) begin
            s_next.wp  = '0;
            s_next.rp  = '0;
            s_next.cnt = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        s_reg <= s_next;
    end
endmodule

module du_chan
    import du_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [2:0] idx_i,
    input  wire logic [7:0] wdata_i,
    output logic [7:0]      rdata_o,
    output logic            thr_busy_o,
    input  wire logic       rx_i,
    input  wire logic       cts_n_i,
    input  wire logic       dsr_n_i,
    input  wire logic       ri_n_i,
    input  wire logic       cd_n_i,
    output logic            tx_o,
    output logic            rts_n_o,
    output logic            dtr_n_o,
    output logic            irq_o,
    output logic            irq_oe_o
);
    typedef enum logic {TX_IDLE, TX_RUN} du_tx_type;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} du_rx_type;
    typedef struct packed {
        logic [7:0]  ier, line_control_reg, modem_control_reg, spr, dll, dlm, fcr;
        logic [3:0]  msr_d, m1, m2, m3;
        logic        rx1, rx2, oe, pe, fe, tick;
        logic [15:0] bcnt;
        du_tx_type   tx_st;
        logic [12:0] tx_sh;
        logic [3:0]  tx_n, tx_ph;
        logic        tx_line, tx_pin;
        du_rx_type   rx_st;
        logic [10:0] rx_sh;
        logic [3:0]  rx_n, rx_ph;
        logic        rx_push;
        logic [9:0]  rx_word;
        logic        rts_n, dtr_n, irq, irq_oe;
    } du_chan_type;
    du_chan_type s_reg, s_next;

    function automatic logic [7:0] wmask(input logic [7:0] line_control_reg);
        wmask = 8'hff >> (2'h3 - line_control_reg[1:0]);
    endfunction
    function automatic logic [3:0] flen(input logic [7:0] line_control_reg);
        flen = 4'h7 + {2'h0, line_control_reg[1:0]} + {3'h0, line_control_reg[DU_LCR_PEN]}
             + {3'h0, line_control_reg[DU_LCR_STOP]};
    endfunction
    function automatic logic par(input logic [7:0] d,
                                 input logic [7:0] line_control_reg);
        par = ^(d & wmask(line_control_reg)) ^ ~line_control_reg[DU_LCR_EVEN];
    endfunction

    logic       dlab, tx_rdy, tx_val, rx_rdy, rx_val, tx_pop, rx_pop;
    logic [7:0] tx_dat, isr, lsr, modem_status_reg;
    logic [9:0] rx_head;
    logic [4:0] tx_cnt, rx_cnt, trig;
    logic [16:0] bsum;
    logic       rxd, rx_int, rd_lsr, rd_msr;
    logic [10:0] al;
    logic [7:0] rdat;

    assign dlab = s_reg.line_control_reg[DU_LCR_DLAB];

    du_fifo #(.WIDTH(8), .DEPTH(DU_FIFO_DEPTH)) u_txf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .clear_i     (wr_i & idx_i == DU_IDX_ISR & wdata_i[DU_FCR_TXCLR]),
        .in_valid_i  (wr_i & idx_i == DU_IDX_DATA & ~dlab),
        .in_data_i   (wdata_i),
        .in_ready_o  (tx_rdy),
        .out_valid_o (tx_val),
        .out_ready_i (tx_pop),
        .out_data_o  (tx_dat),
        .count_o     (tx_cnt)
    );
    // receive byte buffer with error flags
    du_fifo #(.WIDTH(10), .DEPTH(DU_FIFO_DEPTH)) u_rxf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .clear_i     (wr_i & idx_i == DU_IDX_ISR & wdata_i[DU_FCR_RXCLR]),
        .in_valid_i  (s_reg.rx_push),
        .in_data_i   (s_reg.rx_word),
        .in_ready_o  (rx_rdy),
        .out_valid_o (rx_val),
        .out_ready_i (rx_pop),
        .out_data_o  (rx_head),
        .count_o     (rx_cnt)
    );

    assign thr_busy_o = ~tx_rdy & ~dlab;
    assign tx_pop     = s_reg.tx_st == TX_IDLE & tx_val;
    assign rx_pop     = rd_i & idx_i == DU_IDX_DATA & ~dlab;
    assign rdata_o    = rdat;

    always_comb begin
        case (s_reg.fcr[7:6])
            2'h0:    trig = DU_TRIG_1;
            2'h1:    trig = DU_TRIG_4;
            2'h2:    trig = DU_TRIG_8;
            default: trig = DU_TRIG_14;
        endcase
        rx_int = rx_cnt >= trig;
        lsr = {1'b0, tx_cnt == '0 & s_reg.tx_st == TX_IDLE, ~tx_val, 1'b0,
               s_reg.fe, s_reg.pe, s_reg.oe, rx_val};
        // low carrier pin reads as carrier present
        modem_status_reg = {~s_reg.m2[3], ~s_reg.m2[2], ~s_reg.m2[1], ~s_reg.m2[0],
               s_reg.msr_d};
        if (s_reg.ier[2] & (s_reg.oe | s_reg.pe | s_reg.fe)) begin
            isr = DU_ISR_LINE;
        end else if (s_reg.ier[0] & rx_int) begin
            isr = DU_ISR_RX;
        end else if (s_reg.ier[1] & ~tx_val) begin
            isr = DU_ISR_TX;
        end else if (s_reg.ier[3] & |s_reg.msr_d) begin
            isr = DU_ISR_MODEM;
        end else begin
            isr = DU_ISR_NONE;
        end
        // divisor bit swaps data and enable slots
        case (idx_i)
            DU_IDX_DATA: rdat = dlab ? s_reg.dll : rx_head[7:0];
            DU_IDX_IER:  rdat = dlab ? s_reg.dlm : s_reg.ier;
            DU_IDX_ISR:  rdat = isr;
            DU_IDX_LCR:  rdat = s_reg.line_control_reg;
            DU_IDX_MCR:  rdat = s_reg.modem_control_reg;
            DU_IDX_LSR:  rdat = lsr;
            DU_IDX_MSR:  rdat = modem_status_reg;
            default:     rdat = s_reg.spr;
        endcase
    end

    always_comb begin
        s_next = s_reg;
        rd_lsr = rd_i & idx_i == DU_IDX_LSR;
        rd_msr = rd_i & idx_i == DU_IDX_MSR;
        al     = '0;
        // Register writes
        if (wr_i) begin
            case (idx_i)
                DU_IDX_DATA: if (dlab) s_next.dll = wdata_i;
                DU_IDX_IER: begin
                    if (dlab) s_next.dlm = wdata_i;
                    else s_next.ier = {4'h0, wdata_i[3:0]};
                end
                DU_IDX_ISR:  s_next.fcr = wdata_i;
                DU_IDX_LCR:  s_next.line_control_reg = wdata_i;
                DU_IDX_MCR:  s_next.modem_control_reg = {3'h0, wdata_i[4:0]};
                DU_IDX_SPR:  s_next.spr = wdata_i;
                default: ;
            endcase
        end
        // Synchronisers and modem line change detect
        s_next.m1 = {cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
        s_next.m2 = s_reg.m1;
        s_next.m3 = s_reg.m2;
        s_next.rx1 = rx_i;
        s_next.rx2 = s_reg.rx1;
        s_next.msr_d = rd_msr ? 4'h0 : s_reg.msr_d;
        // ring pin rising sets trailing-edge flag
        s_next.msr_d = s_next.msr_d
                     | {s_reg.m2[3] ^ s_reg.m3[3],
                        s_reg.m2[2] & ~s_reg.m3[2],
                        s_reg.m2[1:0] ^ s_reg.m3[1:0]};
        // 16x bit-rate tick
        bsum = {1'b0, s_reg.bcnt} + 17'h00001;
        s_next.tick = bsum >= {1'b0, s_reg.dlm, s_reg.dll};
        s_next.bcnt = s_next.tick ? 16'h0000 : bsum[15:0];
        // modem inputs take no part in the data path
        // start bit, data, then stop bits shifted out
        case (s_reg.tx_st)
            TX_IDLE: begin
                if (tx_val) begin
                    s_next.tx_sh = {4'hf, tx_dat | ~wmask(s_reg.line_control_reg), 1'b0};
                    if (s_reg.line_control_reg[DU_LCR_PEN]) begin
                        s_next.tx_sh[4'h6 + {2'h0, s_reg.line_control_reg[1:0]}] =
                            par(tx_dat, s_reg.line_control_reg);
                    end
                    s_next.tx_n  = flen(s_reg.line_control_reg);
                    s_next.tx_ph = 4'h0;
                    s_next.tx_st = TX_RUN;
                end
            end
            TX_RUN: begin
                if (s_reg.tick) begin
                    s_next.tx_ph = s_reg.tx_ph + 4'h1;
                    if (s_reg.tx_ph == DU_OVS_LAST) begin
                        s_next.tx_sh = {1'b1, s_reg.tx_sh[12:1]};
                        s_next.tx_n  = s_reg.tx_n - 4'h1;
                        if (s_reg.tx_n == 4'h1) s_next.tx_st = TX_IDLE;
                    end
                end
            end
            default: s_next.tx_st = TX_IDLE;
        endcase
        s_next.tx_line = s_next.tx_st == TX_RUN ? s_next.tx_sh[0] : 1'b1;
        // loop-back keeps the pin high and feeds the receiver
        s_next.tx_pin = s_reg.modem_control_reg[DU_MCR_LOOP] | s_next.tx_line;
        rxd = s_reg.modem_control_reg[DU_MCR_LOOP] ? s_reg.tx_line : s_reg.rx2;
        s_next.rx_push = 1'b0;
        case (s_reg.rx_st)
            RX_IDLE: begin
                s_next.rx_ph = 4'h0;
                if (~rxd) s_next.rx_st = RX_START;
            end
            RX_START: begin
                if (s_reg.tick) begin
                    s_next.rx_ph = s_reg.rx_ph + 4'h1;
                    if (s_reg.rx_ph == DU_OVS_MID) begin
                        s_next.rx_st = rxd ? RX_IDLE : RX_BITS;
                        s_next.rx_ph = 4'h0;
                        s_next.rx_n  = flen(s_reg.line_control_reg) - 4'h1;
                        s_next.rx_sh = '0;
                    end
                end
            end
            RX_BITS: begin
                if (s_reg.tick) begin
                    s_next.rx_ph = s_reg.rx_ph + 4'h1;
                    if (s_reg.rx_ph == DU_OVS_LAST) begin
                        s_next.rx_sh = {rxd, s_reg.rx_sh[10:1]};
                        s_next.rx_n  = s_reg.rx_n - 4'h1;
                        if (s_reg.rx_n == 4'h1) begin
                            al = s_next.rx_sh >> (DU_RX_SH_W
                                 - (flen(s_reg.line_control_reg) - 4'h1));
                            s_next.rx_word[7:0] = al[7:0] & wmask(s_reg.line_control_reg);
                            s_next.rx_word[8] = s_reg.line_control_reg[DU_LCR_PEN]
                                & (al[4'h5 + {2'h0, s_reg.line_control_reg[1:0]}]
                                   != par(al[7:0], s_reg.line_control_reg));
                            s_next.rx_word[9] = ~al[4'h5
                                + {2'h0, s_reg.line_control_reg[1:0]}
                                + {3'h0, s_reg.line_control_reg[DU_LCR_PEN]}];
                            s_next.rx_push = rx_rdy;
                            s_next.rx_st = RX_IDLE;
                        end
                    end
                end
            end
            default: s_next.rx_st = RX_IDLE;
        endcase
        // Sticky line errors; a new event wins over the clearing read
        s_next.oe = (s_reg.oe & ~rd_lsr) | (s_reg.rx_push & ~rx_rdy)
                  | (s_next.rx_st == RX_IDLE & s_reg.rx_st == RX_BITS
                     & ~rx_rdy);
        s_next.pe = (s_reg.pe & ~rd_lsr) | (s_reg.rx_push & s_reg.rx_word[8]);
        s_next.fe = (s_reg.fe & ~rd_lsr) | (s_reg.rx_push & s_reg.rx_word[9]);
        // terminal-ready pin follows its bit inverted
        s_next.dtr_n = ~s_next.modem_control_reg[DU_MCR_DTR];
        // request-to-send pin follows its bit inverted
        s_next.rts_n = ~s_next.modem_control_reg[DU_MCR_RTS];
        s_next.irq = isr[0] == 1'b0;
        s_next.irq_oe = s_next.modem_control_reg[DU_MCR_OUT2];
        if (rst_i) begin
            s_next = '0;
            s_next.dll = DU_DLL_RST;
            s_next.line_control_reg = DU_REG_RST;
            s_next.modem_control_reg = DU_REG_RST;
            s_next.m1 = 4'hf;
            s_next.m2 = 4'hf;
            s_next.m3 = 4'hf;
            s_next.rx1 = 1'b1;
            s_next.rx2 = 1'b1;
            s_next.tx_line = 1'b1;
            s_next.tx_pin = 1'b1;
            s_next.dtr_n = 1'b1;
            s_next.rts_n = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        s_reg <= s_next;
    end

    assign tx_o     = s_reg.tx_pin;
    assign rts_n_o  = s_reg.rts_n;
    assign dtr_n_o  = s_reg.dtr_n;
    assign irq_o    = s_reg.irq;
    assign irq_oe_o = s_reg.irq_oe;
endmodule

module du_dual
    import du_pkg::*;
(
    input  wire logic                CLK_I,
    input  wire logic                SYS_RST_I,
    input  wire logic                CYC_I,
    input  wire logic                STB_I,
    input  wire logic                WE_I,
    input  wire logic [DU_ADR_W-1:0] ADR_I,
    input  wire logic [3:0]          SEL_I,
    input  wire logic [31:0]         DAT_I,
    output logic [31:0]              DAT_O,
    output logic                     ACK_O,
    input  wire logic [1:0]          SERIAL_IN_I,
    input  wire logic [1:0]          CTS_N_I,
    input  wire logic [1:0]          DSR_N_I,
    input  wire logic [1:0]          RI_N_I,
    input  wire logic [1:0]          CARRIER_DETECT_N_I,
    output logic [1:0]               SERIAL_OUT_O,
    output logic [1:0]               RTS_N_O,
    output logic [1:0]               DTR_N_O,
    output logic [1:0]               IRQ_O,
    output logic [1:0]               IRQ_OE_O
);
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } du_bus_type;
    du_bus_type s_reg, s_next;
    logic [1:0][7:0] rdata;
    logic [1:0]      busy, cs, wr, rd;
    logic            req, mapped, ch, go;

    for (genvar c = 0; c < 2; c++) begin : g_chan
        du_chan u_chan (
            .clk_i      (CLK_I),
            .rst_i      (SYS_RST_I),
            .wr_i       (wr[c]),
            .rd_i       (rd[c]),
            .idx_i      (ADR_I[4:2]),
            .wdata_i    (DAT_I[7:0]),
            .rdata_o    (rdata[c]),
            .thr_busy_o (busy[c]),
            .rx_i       (SERIAL_IN_I[c]),
            .cts_n_i    (CTS_N_I[c]),
            .dsr_n_i    (DSR_N_I[c]),
            .ri_n_i     (RI_N_I[c]),
            .cd_n_i     (CARRIER_DETECT_N_I[c]),
            .tx_o       (SERIAL_OUT_O[c]),
            .rts_n_o    (RTS_N_O[c]),
            .dtr_n_o    (DTR_N_O[c]),
            .irq_o      (IRQ_O[c]),
            .irq_oe_o   (IRQ_OE_O[c])
        );
    end

    always_comb begin
        s_next = s_reg;
        req    = CYC_I & STB_I & ~s_reg.ack;
        mapped = ADR_I[DU_ADR_W-1:DU_CHAN_BIT+1] == '0;
        ch     = ADR_I[DU_CHAN_BIT];
        // address bit acts as per-channel select
        cs     = {req & mapped & ch, req & mapped & ~ch};
        // Full transmit buffer holds the bus cycle off
        go     = req & ~(mapped & WE_I & SEL_I[0] & busy[ch]
                 & ADR_I[4:2] == DU_IDX_DATA);
        wr     = cs & {2{go & WE_I & SEL_I[0]}};
        rd     = cs & {2{go & ~WE_I}};
        s_next.ack = go;
        s_next.dat = (go & ~WE_I & mapped) ? {24'h000000, rdata[ch]}
                                           : 32'h00000000;
        if (SYS_RST_I) begin
            s_next = '0;
        end
    end

    always_ff @(posedge CLK_I) begin
        s_reg <= s_next;
    end

    assign ACK_O = s_reg.ack;
    assign DAT_O = s_reg.dat;
endmodule

//--- rtl/du_pkg.sv
// Purpose: Constants shared by the dual serial channel design
// Assumes: Register index times four gives the byte address
// Notes:   Channel select is one address bit above the index
package du_pkg;
    localparam int         DU_ADR_W      = 8;
    localparam int         DU_CHAN_BIT   = 5;
    localparam int         DU_FIFO_DEPTH = 16;
    localparam logic [2:0] DU_IDX_DATA   = 3'h0;
    localparam logic [2:0] DU_IDX_IER    = 3'h1;
    localparam logic [2:0] DU_IDX_ISR    = 3'h2;
    localparam logic [2:0] DU_IDX_LCR    = 3'h3;
    localparam logic [2:0] DU_IDX_MCR    = 3'h4;
    localparam logic [2:0] DU_IDX_LSR    = 3'h5;
    localparam logic [2:0] DU_IDX_MSR    = 3'h6;
    localparam logic [2:0] DU_IDX_SPR    = 3'h7;
    localparam logic [7:0] DU_REG_RST    = 8'h00;
    localparam logic [7:0] DU_DLL_RST    = 8'h01;
    localparam int         DU_MCR_DTR    = 0;
    localparam int         DU_MCR_RTS    = 1;
    localparam int         DU_MCR_OUT2   = 3;
    localparam int         DU_MCR_LOOP   = 4;
    localparam int         DU_LCR_STOP   = 2;
    localparam int         DU_LCR_PEN    = 3;
    localparam int         DU_LCR_EVEN   = 4;
    localparam int         DU_LCR_DLAB   = 7;
    localparam int         DU_FCR_RXCLR  = 1;
    localparam int         DU_FCR_TXCLR  = 2;
    localparam logic [3:0] DU_OVS_LAST   = 4'hf;
    localparam logic [3:0] DU_OVS_MID    = 4'h7;
    localparam logic [3:0] DU_RX_SH_W    = 4'hb;
    localparam logic [4:0] DU_TRIG_1     = 5'h01;
    localparam logic [4:0] DU_TRIG_4     = 5'h04;
    localparam logic [4:0] DU_TRIG_8     = 5'h08;
    localparam logic [4:0] DU_TRIG_14    = 5'h0e;
    localparam logic [7:0] DU_ISR_LINE   = 8'hc6;
    localparam logic [7:0] DU_ISR_RX     = 8'hc4;
    localparam logic [7:0] DU_ISR_TX     = 8'hc2;
    localparam logic [7:0] DU_ISR_MODEM  = 8'hc0;
    localparam logic [7:0] DU_ISR_NONE   = 8'hc1;
endpackage

//--- sim/du_partner.sv
// Purpose: Null-modem cable between the two serial channels
// Assumes: Both far ends are channels of the same block
// Notes:   Ring lines are driven by the bench
`timescale 1ns/10ps

module du_partner (
    input  wire logic [1:0] tx_i,
    input  wire logic [1:0] rts_n_i,
    input  wire logic [1:0] dtr_n_i,
    input  wire logic [1:0] ring_n_i,
    output logic [1:0]      rx_o,
    output logic [1:0]      cts_n_o,
    output logic [1:0]      dsr_n_o,
    output logic [1:0]      cd_n_o,
    output logic [1:0]      ri_n_o
);
    // Each channel hears the other one
    assign rx_o    = {tx_i[0], tx_i[1]};
    assign cts_n_o = {rts_n_i[0], rts_n_i[1]};
    assign dsr_n_o = {dtr_n_i[0], dtr_n_i[1]};
    // carrier low while far end ready
    assign cd_n_o  = {dtr_n_i[0], dtr_n_i[1]};
    assign ri_n_o  = ring_n_i;
endmodule

//--- sim/du_dual_asserts.sv
// Purpose: Bus and pin assertions for the dual serial block
// Assumes: Divisor of 1, so each serial bit lasts 16 clocks
// Notes:   Sees the top module ports only
`timescale 1ns/10ps

module du_dual_asserts
    import du_pkg::*;
(
    input wire logic        CLK_I,
    input wire logic        SYS_RST_I,
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        WE_I,
    input wire logic [31:0] DAT_O,
    input wire logic        ACK_O,
    input wire logic [1:0]  SERIAL_OUT_O,
    input wire logic [1:0]  RTS_N_O,
    input wire logic [1:0]  DTR_N_O,
    input wire logic [1:0]  IRQ_OE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    logic       tx_reg;
    logic [4:0] run_reg;
    // Clocks since the last change of the channel A serial line
    always_ff @(posedge CLK_I) begin
        tx_reg <= SERIAL_OUT_O[0];
        if (SYS_RST_I) begin
            run_reg <= 5'h1f;
        end else if (SERIAL_OUT_O[0] != tx_reg) begin
            run_reg <= 5'h01;
        end else if (run_reg != 5'h1f) begin
            run_reg <= run_reg + 5'h01;
        end
    end
    a_ack_one_pulse: assert property (ACK_O |=> !ACK_O)
        else $error("ack longer than one cycle");
    a_ack_has_req: assert property (ACK_O |-> $past(CYC_I & STB_I))
        else $error("ack without request");
    a_read_ack_next: assert property (CYC_I && STB_I && !WE_I
        && !ACK_O |=> ACK_O)
        else $error("read not answered next cycle");
    a_data_idle_zero: assert property (!ACK_O |-> DAT_O == 32'h0)
        else $error("read data outside ack");
    a_reset_pins_high: assert property (disable iff (1'b0)
        SYS_RST_I |=> SERIAL_OUT_O == 2'h3 && RTS_N_O == 2'h3
        && DTR_N_O == 2'h3 && IRQ_OE_O == 2'h0)
        else $error("pins not idle in reset");
    a_dtr_by_write: assert property ($changed(DTR_N_O)
        |-> $past(CYC_I & STB_I & WE_I) || $past(CYC_I & STB_I & WE_I, 2))
        else $error("terminal ready moved without write");
    a_rts_by_write: assert property ($changed(RTS_N_O)
        |-> $past(CYC_I & STB_I & WE_I) || $past(CYC_I & STB_I & WE_I, 2))
        else $error("request to send moved without write");
    a_bit_time: assert property (SERIAL_OUT_O[0] != tx_reg
        |-> run_reg >= 5'h10)
        else $error("serial bit shorter than 16 clocks");
    c_read: cover property (ACK_O && !WE_I);
    c_start: cover property ($fell(SERIAL_OUT_O[0]));
    c_dtr_on: cover property ($fell(DTR_N_O[0]));
endmodule

bind du_dual du_dual_asserts i_chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .SERIAL_OUT_O(SERIAL_OUT_O), .RTS_N_O(RTS_N_O), .DTR_N_O(DTR_N_O),
    .IRQ_OE_O(IRQ_OE_O));

//--- sim/tb_du_dual.sv
// Purpose: Self-checking bench for the dual serial block
// Assumes: Divisor 1, so an 8E1 character takes 176 clocks
// Notes:   Channel A talks to channel B through a null-modem cable
`timescale 1ns/10ps

module tb_du_dual;
    import du_pkg::*;
    logic        clk = 1'b0;
    logic        rst, cyc, stb, we, ok;
    logic [7:0]  adr, b, e, m;
    logic [31:0] dat, dat_o;
    logic        ack;
    logic [3:0]  sel = 4'hf;
    logic [1:0]  sin, cts_n, dsr_n, ri_n, cd_n, sout, rts_n, dtr_n, irq, oe;
    logic [1:0]  ring;
    logic [7:0]  eq[$], mq[$], sent[$];
    int          errors = 0, n_checks = 0, cycles = 0;

    always #5 clk = ~clk;

    du_dual i_dut (.CLK_I(clk), .SYS_RST_I(rst), .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o),
        .ACK_O(ack), .SERIAL_IN_I(sin), .CTS_N_I(cts_n), .DSR_N_I(dsr_n),
        .RI_N_I(ri_n), .CARRIER_DETECT_N_I(cd_n), .SERIAL_OUT_O(sout),
        .RTS_N_O(rts_n), .DTR_N_O(dtr_n), .IRQ_O(irq), .IRQ_OE_O(oe));
    du_partner i_far (.tx_i(sout), .rts_n_i(rts_n), .dtr_n_i(dtr_n),
        .ring_n_i(ring), .rx_o(sin), .cts_n_o(cts_n), .dsr_n_o(dsr_n),
        .cd_n_o(cd_n), .ri_n_o(ri_n));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    function automatic logic [7:0] ad(input logic ch, input logic [2:0] i);
        return {2'b00, ch, i, 2'b00};
    endfunction

    // Classic cycle; a read notes expected value d under mask mk
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d, input logic [7:0] mk);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= {24'h0, d};
        if (!w) begin
            eq.push_back(d);
            mq.push_back(mk);
        end
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && eq.size() > 0) begin
            e = eq.pop_front();
            m = mq.pop_front();
            if (m != 8'h00) begin
                check(dat_o & 32'(m), 32'(e & m));
            end
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            errors++;
            wrap_up();
        end
    end

    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        dat = 32'h0;
        ring = 2'h3;
        void'($urandom(32'h4399));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        #1 check({24'h0, sout, dtr_n, rts_n, oe}, 32'hfc);
        wb(1'b0, ad(1'b1, DU_IDX_MSR), 8'h00, 8'h00);
        wb(1'b0, ad(1'b0, DU_IDX_LCR), DU_REG_RST, 8'hff);
        wb(1'b1, ad(1'b0, DU_IDX_LCR), 8'h80, 8'h00);
        wb(1'b1, ad(1'b0, DU_IDX_DATA), DU_DLL_RST, 8'h00);
        wb(1'b0, ad(1'b0, DU_IDX_DATA), DU_DLL_RST, 8'hff);
        wb(1'b1, ad(1'b0, DU_IDX_LCR), DU_REG_RST, 8'h00);
        wb(1'b0, ad(1'b0, DU_IDX_LSR), 8'h60, 8'hff);
        wb(1'b1, ad(1'b0, DU_IDX_MCR), 8'h0b, 8'h00);
        repeat (8) @(posedge clk);
        #1 check({28'h0, dtr_n, rts_n}, 32'h0a);
        check({28'h0, irq, oe}, 32'h1);
        wb(1'b0, ad(1'b1, DU_IDX_MSR), 8'hbb, 8'hff);
        @(posedge clk);
        ring <= 2'h1;
        repeat (8) @(posedge clk);
        ring <= 2'h3;
        repeat (8) @(posedge clk);
        wb(1'b0, ad(1'b1, DU_IDX_MSR), 8'hb4, 8'hff);
        wb(1'b1, ad(1'b0, DU_IDX_LCR), 8'h1b, 8'h00);
        wb(1'b1, ad(1'b1, DU_IDX_LCR), 8'h1b, 8'h00);
        wb(1'b1, ad(1'b1, DU_IDX_ISR), 8'hc0, 8'h00);
        wb(1'b1, ad(1'b1, DU_IDX_IER), 8'h01, 8'h00);
        for (int i = 0; i < DU_FIFO_DEPTH; i++) begin
            b = 8'($urandom);
            sent.push_back(b);
            wb(1'b1, ad(1'b0, DU_IDX_DATA), b, 8'h00);
        end
        repeat (DU_FIFO_DEPTH * 176 + 40) @(posedge clk);
        wb(1'b0, ad(1'b1, DU_IDX_LSR), 8'h01, 8'h0f);
        wb(1'b0, ad(1'b1, DU_IDX_ISR), DU_ISR_RX, 8'hff);
        #1 check({30'h0, irq}, 32'h2);
        for (int i = 0; i < DU_FIFO_DEPTH; i++) begin
            if (i == 3) begin
                wb(1'b0, ad(1'b1, DU_IDX_ISR), DU_ISR_NONE, 8'hff);
            end
            wb(1'b0, ad(1'b1, DU_IDX_DATA), sent.pop_front(), 8'hff);
        end
        wb(1'b0, ad(1'b1, DU_IDX_LSR), 8'h00, 8'h01);
        wb(1'b1, ad(1'b1, DU_IDX_LCR), 8'h0b, 8'h00);
        b = 8'($urandom);
        wb(1'b1, ad(1'b0, DU_IDX_DATA), b, 8'h00);
        repeat (200) @(posedge clk);
        wb(1'b0, ad(1'b1, DU_IDX_LSR), 8'h05, 8'h05);
        wb(1'b0, ad(1'b1, DU_IDX_DATA), b, 8'hff);
        wb(1'b1, ad(1'b0, DU_IDX_MCR), 8'h1b, 8'h00);
        b = 8'($urandom);
        wb(1'b1, ad(1'b0, DU_IDX_DATA), b, 8'h00);
        wb(1'b1, ad(1'b1, DU_IDX_DATA), ~b, 8'h00);
        ok = 1'b1;
        repeat (200) begin
            @(posedge clk);
            ok = ok & sout[0];
        end
        check({31'h0, ok}, 32'h1);
        wb(1'b0, ad(1'b0, DU_IDX_DATA), b, 8'hff);
        wb(1'b0, ad(1'b0, DU_IDX_LSR), 8'h00, 8'h01);
        wb(1'b0, ad(1'b1, DU_IDX_LSR), 8'h00, 8'h01);
        repeat (4) @(posedge clk);
        wrap_up();
    end
endmodule
